// ==== common/alarm_pkg.sv ====
// package: register map, field positions and bus types for the alarm status block
package alarm_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_ALARM = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_MASK = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_LANE = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h010;
    localparam int NUM_LANES = 8;
    localparam int BIT_FIFO = 5;
    localparam int BIT_PLL = 4;
    localparam int BIT_LINK = 3;
    localparam int BIT_REALIGN = 2;
    localparam int BIT_CLK = 0;
    localparam int BIT_CTRL_LINK_EN = 0;
    localparam int BIT_CTRL_MODE = 1;
    localparam int BIT_CTRL_PIN_SEL = 2;
    localparam int BIT_CTRL_SOFT_RST = 3;
    localparam logic [7:0] FLAG_BITS = 8'h3F;
    localparam logic [7:0] STATUS_RST = 8'h3F;
    localparam logic [7:0] MASK_RST = 8'h3F;
    localparam logic [7:0] LANE_RST = 8'hFF;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] lane_fifo_fault;
        logic serdes_pll_unlocked;
        logic data_phase_state;
        logic realign_event;
        logic divider_mismatch;
    } alarm_cond_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;
endpackage

// ==== hw/alarm_status_flags.sv ====
// alarm status flags with mask, summary alarm, per-lane fifo faults and axi4-lite slave
`timescale 1ns/10ps
module alarm_status_flags (
    input wire logic CLK_SYS, // system clock, 100 MHz
    input wire logic RST, // synchronous reset, active high
    input wire alarm_pkg::alarm_cond_t COND, // raw alarm conditions
    input wire logic REALIGN_64B, // fifo or serializer realignment, 64b/66b mode
    input wire logic CAL_DONE, // calibration status from calibration engine
    input wire alarm_pkg::axil_req_t AXI_REQ, // axi4-lite master to slave
    output alarm_pkg::axil_rsp_t AXI_RSP, // axi4-lite slave to master
    output logic LINK_ENABLE, // link enable control
    output logic MODE_64B66B, // 1 = 64b/66b, 0 = 8b/10b
    output logic CALIBRATION_STATUS_PIN, // calibration status or alarm
    output logic IRQ // summary alarm interrupt, level
);
    import alarm_pkg::*;

    typedef enum logic [2:0] {
        W_IDLE = 3'b001,
        W_RESP = 3'b010,
        W_HOLD = 3'b100
    } wr_state_t;

    logic [7:0] status_q;
    logic [7:0] lane_q;
    logic [7:0] mask_r, mask_nxt;
    logic [2:0] ctrl_r, ctrl_nxt;
    logic soft_rst_r, soft_rst_nxt;
    logic link_en_d_r, link_en_d_nxt;
    logic cal_pin_r, cal_pin_nxt;
    logic irq_r, irq_nxt;
    logic flag_rst;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] lane_clr;
    logic summary;
    logic link_start;

    // write channel state
    wr_state_t wst_r, wst_nxt;
    logic aw_got_r, aw_got_nxt;
    logic w_got_r, w_got_nxt;
    logic [ADDR_W-1:0] waddr_r, waddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic wr_do;
    logic wr_hit;

    // read channel state
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    // soft reset re-arms every flag like a power-on reset
    assign flag_rst = RST | soft_rst_r;
    assign link_start = ctrl_r[BIT_CTRL_LINK_EN] & ~link_en_d_r;

    // ---------------- alarm set conditions ----------------
    always_comb begin
        set_vec = 8'h00;
        set_vec[BIT_FIFO] = ctrl_r[BIT_CTRL_LINK_EN] & (|COND.lane_fifo_fault);
        set_vec[BIT_PLL] = COND.serdes_pll_unlocked;
        if (ctrl_r[BIT_CTRL_MODE]) begin
            set_vec[BIT_LINK] = link_start | (ctrl_r[BIT_CTRL_LINK_EN] & REALIGN_64B);
        end else begin
            set_vec[BIT_LINK] = ctrl_r[BIT_CTRL_LINK_EN] & ~COND.data_phase_state;
        end
        set_vec[BIT_REALIGN] = COND.realign_event;
        // the pll unlock, realign and divider checks stay active with the link off
        set_vec[BIT_CLK] = COND.divider_mismatch;
    end

    // reserved status bits are never set and never cleared
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_status
            if (FLAG_BITS[gi]) begin : g_flag
                w1c_flag #(.RST_VAL(STATUS_RST[gi])) u_flag (
                    .clk(CLK_SYS),
                    .rst(flag_rst),
                    .set_in(set_vec[gi]),
                    .clr_in(clr_vec[gi]),
                    .flag_q(status_q[gi])
                );
            end else begin : g_rsvd
                assign status_q[gi] = 1'b0;
            end
            w1c_flag #(.RST_VAL(LANE_RST[gi])) u_lane (
                .clk(CLK_SYS),
                .rst(flag_rst),
                .set_in(ctrl_r[BIT_CTRL_LINK_EN] & COND.lane_fifo_fault[gi]),
                .clr_in(lane_clr[gi]),
                .flag_q(lane_q[gi])
            );
        end
    endgenerate

    // ---------------- summary alarm, pin and irq ----------------
    assign summary = |(status_q & ~mask_r & FLAG_BITS);

    always_comb begin
        irq_nxt = summary;
        cal_pin_nxt = ctrl_r[BIT_CTRL_PIN_SEL] ? summary : CAL_DONE;
        link_en_d_nxt = ctrl_r[BIT_CTRL_LINK_EN];
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            irq_r <= 1'b0;
            cal_pin_r <= 1'b0;
            link_en_d_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            cal_pin_r <= cal_pin_nxt;
            link_en_d_r <= link_en_d_nxt;
        end
    end

    // ---------------- axi4-lite write ----------------
    assign wr_do = (wst_r == W_HOLD);
    assign wr_hit = (waddr_r == OFS_STATUS) || (waddr_r == OFS_MASK) ||
                    (waddr_r == OFS_LANE) || (waddr_r == OFS_CTRL);

    always_comb begin
        clr_vec = 8'h00;
        lane_clr = 8'h00;
        if (wr_do && wstrb_r[0]) begin
            if (waddr_r == OFS_STATUS) begin
                clr_vec = wdata_r[7:0] & FLAG_BITS;
                lane_clr = {NUM_LANES{wdata_r[BIT_FIFO]}};
            end else if (waddr_r == OFS_LANE) begin
                lane_clr = wdata_r[7:0];
            end
        end
    end

    always_comb begin
        mask_nxt = mask_r;
        ctrl_nxt = ctrl_r;
        soft_rst_nxt = 1'b0;
        if (wr_do && wstrb_r[0]) begin
            if (waddr_r == OFS_MASK) begin
                mask_nxt = wdata_r[7:0];
            end else if (waddr_r == OFS_CTRL) begin
                ctrl_nxt = wdata_r[2:0];
                soft_rst_nxt = wdata_r[BIT_CTRL_SOFT_RST];
            end
        end
    end

    always_comb begin
        wst_nxt = wst_r;
        aw_got_nxt = aw_got_r;
        w_got_nxt = w_got_r;
        waddr_nxt = waddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        awready_nxt = awready_r;
        wready_nxt = wready_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        case (wst_r)
            W_IDLE: begin
                if (AXI_REQ.awvalid && awready_r) begin
                    aw_got_nxt = 1'b1;
                    waddr_nxt = AXI_REQ.awaddr;
                    awready_nxt = 1'b0;
                end
                if (AXI_REQ.wvalid && wready_r) begin
                    w_got_nxt = 1'b1;
                    wdata_nxt = AXI_REQ.wdata;
                    wstrb_nxt = AXI_REQ.wstrb;
                    wready_nxt = 1'b0;
                end
                if ((aw_got_nxt) && (w_got_nxt)) begin
                    wst_nxt = W_HOLD;
                end
            end
            W_HOLD: begin
                bvalid_nxt = 1'b1;
                bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
                wst_nxt = W_RESP;
            end
            W_RESP: begin
                if (AXI_REQ.bready) begin
                    bvalid_nxt = 1'b0;
                    aw_got_nxt = 1'b0;
                    w_got_nxt = 1'b0;
                    awready_nxt = 1'b1;
                    wready_nxt = 1'b1;
                    wst_nxt = W_IDLE;
                end
            end
            default: begin
                wst_nxt = W_IDLE;
            end
        endcase
    end

    // ---------------- axi4-lite read ----------------
    always_comb begin
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (AXI_REQ.arvalid && arready_r) begin
            arready_nxt = 1'b0;
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            if (AXI_REQ.araddr == OFS_ALARM) begin
                rdata_nxt = {31'h0, summary};
            end else if (AXI_REQ.araddr == OFS_STATUS) begin
                rdata_nxt = {24'h0, status_q};
            end else if (AXI_REQ.araddr == OFS_MASK) begin
                rdata_nxt = {24'h0, mask_r};
            end else if (AXI_REQ.araddr == OFS_LANE) begin
                rdata_nxt = {24'h0, lane_q};
            end else if (AXI_REQ.araddr == OFS_CTRL) begin
                rdata_nxt = {29'h0, ctrl_r};
            end else begin
                rdata_nxt = 32'h0;
                rresp_nxt = RESP_SLVERR;
            end
        end else if (rvalid_r && AXI_REQ.rready) begin
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            mask_r <= MASK_RST;
            ctrl_r <= CTRL_RST;
            soft_rst_r <= 1'b0;
            wst_r <= W_IDLE;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= RESP_OKAY;
        end else begin
            mask_r <= mask_nxt;
            ctrl_r <= ctrl_nxt;
            soft_rst_r <= soft_rst_nxt;
            wst_r <= wst_nxt;
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            waddr_r <= waddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    always_comb begin
        AXI_RSP.awready = awready_r;
        AXI_RSP.wready = wready_r;
        AXI_RSP.bvalid = bvalid_r;
        AXI_RSP.bresp = bresp_r;
        AXI_RSP.arready = arready_r;
        AXI_RSP.rvalid = rvalid_r;
        AXI_RSP.rdata = rdata_r;
        AXI_RSP.rresp = rresp_r;
    end

    assign LINK_ENABLE = ctrl_r[BIT_CTRL_LINK_EN];
    assign MODE_64B66B = ctrl_r[BIT_CTRL_MODE];
    assign CALIBRATION_STATUS_PIN = cal_pin_r;
    assign IRQ = irq_r;

    // ---------------- checks ----------------
    sequence s_clr_write(int b);
        wr_do && wstrb_r[0] && (waddr_r == OFS_STATUS) && wdata_r[b];
    endsequence

    chk_fifo_set: assert property (@(posedge CLK_SYS) disable iff (flag_rst)
        (ctrl_r[BIT_CTRL_LINK_EN] && |COND.lane_fifo_fault) |=> status_q[BIT_FIFO])
        else $error("fifo fault flag not set");
    chk_w1c_clear: assert property (@(posedge CLK_SYS) disable iff (flag_rst)
        (s_clr_write(BIT_CLK) and !set_vec[BIT_CLK]) |=> !status_q[BIT_CLK])
        else $error("flag not cleared by write one");
    chk_zero_keeps: assert property (@(posedge CLK_SYS) disable iff (flag_rst)
        (status_q[BIT_PLL] && !clr_vec[BIT_PLL]) |=> status_q[BIT_PLL])
        else $error("flag lost without clear");
    chk_pll_set: assert property (@(posedge CLK_SYS) disable iff (flag_rst)
        COND.serdes_pll_unlocked |=> status_q[BIT_PLL])
        else $error("pll unlock flag not set");
    chk_link_8b: assert property (@(posedge CLK_SYS) disable iff (flag_rst)
        (!ctrl_r[BIT_CTRL_MODE] && ctrl_r[BIT_CTRL_LINK_EN] && !COND.data_phase_state)
        |=> status_q[BIT_LINK])
        else $error("link down flag not set in 8b10b");
    chk_link_start: assert property (@(posedge CLK_SYS) disable iff (flag_rst)
        (ctrl_r[BIT_CTRL_MODE] && $rose(ctrl_r[BIT_CTRL_LINK_EN])) |=> status_q[BIT_LINK])
        else $error("link down flag not set at start-up");
    chk_realign_set: assert property (@(posedge CLK_SYS) disable iff (flag_rst)
        COND.realign_event |=> status_q[BIT_REALIGN])
        else $error("realign flag not set");
    chk_soft_reset: assert property (@(posedge CLK_SYS) disable iff (RST)
        soft_rst_r |=> (status_q == STATUS_RST) && (lane_q == LANE_RST))
        else $error("soft reset did not set flags");
    chk_summary_irq: assert property (@(posedge CLK_SYS) disable iff (RST)
        ##1 (IRQ == $past(summary)))
        else $error("irq does not follow summary");
    chk_mask_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
        (mask_r == MASK_RST) |-> !summary)
        else $error("masked alarm reached summary");
    chk_lane_clear: assert property (@(posedge CLK_SYS) disable iff (flag_rst)
        (s_clr_write(BIT_FIFO) and !(ctrl_r[BIT_CTRL_LINK_EN] && |COND.lane_fifo_fault))
        |=> (lane_q == 8'h00))
        else $error("lane bits not cleared with fifo flag");
    chk_pin_alarm: assert property (@(posedge CLK_SYS) disable iff (RST)
        ctrl_r[BIT_CTRL_PIN_SEL] |=> (CALIBRATION_STATUS_PIN == $past(summary)))
        else $error("alarm not on calibration pin");
    chk_set_wins: assert property (@(posedge CLK_SYS) disable iff (flag_rst)
        (s_clr_write(BIT_PLL) and COND.serdes_pll_unlocked) |=> status_q[BIT_PLL])
        else $error("clear beat a simultaneous set");
endmodule

// ==== hw/w1c_flag.sv ====
// one sticky flag: reset value, set by hardware, cleared by software writing one
`timescale 1ns/10ps
module w1c_flag #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic set_in, // hardware condition
    input wire logic clr_in, // software clear strobe
    output logic flag_q // stored flag
);
    logic flag_nxt;

    always_comb begin
        flag_nxt = flag_q;
        if (clr_in) begin
            flag_nxt = 1'b0;
        end
        if (set_in) begin
            flag_nxt = 1'b1; // set beats clear
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= RST_VAL;
        end else begin
            flag_q <= flag_nxt;
        end
    end
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the alarm status block over its axi4-lite port
`timescale 1ns/10ps
module tb;
    import alarm_pkg::*;
    typedef struct {alarm_cond_t c; logic [7:0] st;} row_t;
    localparam alarm_cond_t QUIET = '{8'h00, 1'h0, 1'h1, 1'h0, 1'h0};
    logic clk_sys;
    logic rst;
    alarm_cond_t cond;
    logic realign_64b;
    logic cal_done;
    axil_req_t req;
    axil_rsp_t rsp;
    logic link_enable;
    logic mode_64b66b;
    logic pin;
    logic irq;
    logic [31:0] rdat;
    logic [1:0] resp;
    int fail_count;
    int comparisons;
    row_t rows[5];

    alarm_status_flags alarm_status_flags_i (
        .CLK_SYS(clk_sys),
        .RST(rst),
        .COND(cond),
        .REALIGN_64B(realign_64b),
        .CAL_DONE(cal_done),
        .AXI_REQ(req),
        .AXI_RSP(rsp),
        .LINK_ENABLE(link_enable),
        .MODE_64B66B(mode_64b66b),
        .CALIBRATION_STATUS_PIN(pin),
        .IRQ(irq)
    );

    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // master holds every channel until its own ready edge, bready until bvalid
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw_ok;
        logic w_ok;
        logic b_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        b_ok = 1'h0;
        n = 0;
        r = 2'h3;
        @(posedge clk_sys);
        req.awvalid <= 1'h1;
        req.awaddr <= a;
        req.wvalid <= 1'h1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.bready <= 1'h1;
        while (!b_ok && n < 100) begin
            @(posedge clk_sys);
            n++;
            if (!aw_ok && rsp.awready) begin
                aw_ok = 1'h1;
                req.awvalid <= 1'h0;
            end
            if (!w_ok && rsp.wready) begin
                w_ok = 1'h1;
                req.wvalid <= 1'h0;
            end
            if (rsp.bvalid) begin
                b_ok = 1'h1;
                r = rsp.bresp;
                req.bready <= 1'h0;
            end
        end
        if (!b_ok) check("write response", 32'h1, 32'h0);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic a_ok;
        logic r_ok;
        a_ok = 1'h0;
        r_ok = 1'h0;
        n = 0;
        d = 32'h0;
        r = 2'h3;
        @(posedge clk_sys);
        req.arvalid <= 1'h1;
        req.araddr <= a;
        req.rready <= 1'h1;
        while (!r_ok && n < 100) begin
            @(posedge clk_sys);
            n++;
            if (!a_ok && rsp.arready) begin
                a_ok = 1'h1;
                req.arvalid <= 1'h0;
            end
            if (rsp.rvalid) begin
                r_ok = 1'h1;
                d = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'h0;
            end
        end
        if (!r_ok) check("read response", 32'h1, 32'h0);
    endtask

    task automatic rc(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        check(name, exp, d);
    endtask

    task automatic wq(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask

    // irq is registered one cycle behind the summary, pin one cycle behind summary or cal_done
    task automatic settle_pins(input logic [31:0] e_irq, input logic [31:0] e_pin);
        repeat (2) @(posedge clk_sys);
        #1;
        check("irq", e_irq, {31'h0, irq});
        check("cal pin", e_pin, {31'h0, pin});
    endtask

    task automatic pulse(input alarm_cond_t c);
        @(posedge clk_sys);
        cond <= c;
        repeat (2) @(posedge clk_sys);
        cond <= QUIET;
        repeat (2) @(posedge clk_sys);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        $display("Error watchdog expected done seen hang");
        fail_count++;
        summarize();
    end

    initial begin
        rst = 1'h1;
        cond = QUIET;
        realign_64b = 1'h0;
        cal_done = 1'h0;
        req = '0;
        fail_count = 0;
        comparisons = 0;
        rows[0] = '{'{8'h04, 1'h0, 1'h1, 1'h0, 1'h0}, 8'h20};
        rows[1] = '{'{8'h00, 1'h1, 1'h1, 1'h0, 1'h0}, 8'h10};
        rows[2] = '{'{8'h00, 1'h0, 1'h0, 1'h0, 1'h0}, 8'h08};
        rows[3] = '{'{8'h00, 1'h0, 1'h1, 1'h1, 1'h0}, 8'h04};
        rows[4] = '{'{8'h00, 1'h0, 1'h1, 1'h0, 1'h1}, 8'h01};
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        rc("status rst", OFS_STATUS, 32'h3F);
        rc("lane rst", OFS_LANE, 32'hFF);
        rc("mask rst", OFS_MASK, 32'h3F);
        rc("summary rst", OFS_ALARM, 32'h0);
        rc("ctrl rst", OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h01, resp);
        check("bresp okay", {30'h0, RESP_OKAY}, {30'h0, resp});
        check("link enable", 32'h1, {31'h0, link_enable});
        wq(OFS_STATUS, 32'h3F);
        rc("status clr", OFS_STATUS, 32'h0);
        rc("lane clr", OFS_LANE, 32'h0);
        // one alarm source per row, then cleared by a single w1c write
        for (int i = 0; i < 5; i++) begin
            pulse(rows[i].c);
            rc("status set", OFS_STATUS, {24'h0, rows[i].st});
            rc("lane set", OFS_LANE, {24'h0, rows[i].c.lane_fifo_fault});
            wq(OFS_STATUS, 32'h3F);
            rc("status w1c", OFS_STATUS, 32'h0);
            rc("lane follow", OFS_LANE, 32'h0);
        end
        pulse('{8'h00, 1'h1, 1'h1, 1'h0, 1'h0});
        wq(OFS_STATUS, 32'h2F);
        rc("status zero kept", OFS_STATUS, 32'h10);
        // unlock stands only in the cycle in which the clear lands
        @(posedge clk_sys);
        fork
            wq(OFS_STATUS, 32'h10);
            begin
                repeat (2) @(posedge clk_sys);
                cond.serdes_pll_unlocked <= 1'h1;
                @(posedge clk_sys);
                cond.serdes_pll_unlocked <= 1'h0;
            end
        join
        rc("set beats clear", OFS_STATUS, 32'h10);
        cond <= QUIET;
        settle_pins(32'h0, 32'h0);
        wq(OFS_MASK, 32'h2F);
        rc("mask rw", OFS_MASK, 32'h2F);
        rc("summary on", OFS_ALARM, 32'h1);
        cal_done <= 1'h1;
        settle_pins(32'h1, 32'h1);
        cal_done <= 1'h0;
        settle_pins(32'h1, 32'h0);
        wq(OFS_CTRL, 32'h05);
        settle_pins(32'h1, 32'h1);
        wq(OFS_STATUS, 32'h10);
        rc("summary off", OFS_ALARM, 32'h0);
        settle_pins(32'h0, 32'h0);
        // 64b/66b: data phase is meaningless, start-up and realignment raise link-down
        cond.data_phase_state <= 1'h0;
        wq(OFS_CTRL, 32'h02);
        wq(OFS_STATUS, 32'h3F);
        wq(OFS_CTRL, 32'h03);
        check("mode", 32'h1, {31'h0, mode_64b66b});
        rc("link start", OFS_STATUS, 32'h08);
        wq(OFS_STATUS, 32'h3F);
        rc("no data phase", OFS_STATUS, 32'h0);
        @(posedge clk_sys);
        realign_64b <= 1'h1;
        @(posedge clk_sys);
        realign_64b <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rc("realign 64b", OFS_STATUS, 32'h08);
        wq(OFS_CTRL, 32'h0B);
        repeat (3) @(posedge clk_sys);
        rc("soft status", OFS_STATUS, 32'h3F);
        rc("soft lane", OFS_LANE, 32'hFF);
        rc("soft mask", OFS_MASK, 32'h2F);
        rc("soft ctrl", OFS_CTRL, 32'h03);
        rd(12'h100, rdat, resp);
        check("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        check("unmapped rdata", 32'h0, rdat);
        wr(12'h100, 32'hFF, resp);
        check("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        cond <= QUIET;
        wq(OFS_STATUS, 32'h3F);
        @(posedge clk_sys);
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        rc("status rerst", OFS_STATUS, 32'h3F);
        rc("mask rerst", OFS_MASK, 32'h3F);
        rc("ctrl rerst", OFS_CTRL, 32'h0);
        wq(OFS_STATUS, 32'h3F);
        pulse(rows[4].c);
        rc("clk flag link off", OFS_STATUS, 32'h01);
        summarize();
    end
endmodule
